// file: design/sdbg_defs.vh
// Function
// [R1] Speed probe is a line event, not command
// [R2] Host holds pin low 128 slowest cycles
// [R3] Host speedup pulse high, then releases pin
// [R4] Long low interval detected as speed probe
// [R5] Wait pin high, then delay 16 cycles
// [R6] Answer: drive pin low 128 cycles
// [R7] Then one-cycle high speedup, then release
// [R8] Host times answer pulse to derive speed
// [R9] Compare address bus to 16-bit match value
// [R10] Forced: enter debug at next instruction boundary
// [R11] Tagged: mark opcode, break at queue end
// [R12] Match enable bit 5, reset 0, gates all
// [R13] Bit 4: 1 forced, 0 tagged
// [R14] Registers reachable only by serial commands
// [R15] Permit writes ignored while in debug mode
// [R16] Four status flags read-only to control write
// [R17] Clock select writable at all times
// [R18] Permit bit 7 sticky until reset
// [R19] Bit 6 shows debug mode active
// [R20] Status read E4, control write C4
// [R21] Match read E2, write C2, 16 bits
// [R22] Clock select bit 3, 0 alternate source
// [R23] Commands and data sent MSB first
// [R24] Counts use currently selected clock source
`ifndef SDBG_DEFS_VH
`define SDBG_DEFS_VH

// ----------------------------------------
// Status/control field positions
// ----------------------------------------
`define SDBG_BIT_PERMIT      7
`define SDBG_BIT_ACTIVE      6
`define SDBG_BIT_MATCH_EN    5
`define SDBG_BIT_FTS         4
`define SDBG_BIT_CLKSEL      3
`define SDBG_BIT_WS          2
`define SDBG_BIT_WSF         1
`define SDBG_BIT_SAF         0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SDBG_RST_CTRL        1'b0
`define SDBG_RST_MATCH       16'h0000

// ----------------------------------------
// Serial command codes
// ----------------------------------------
`define SDBG_CMD_RD_STATUS   8'he4
`define SDBG_CMD_WR_CONTROL  8'hc4
`define SDBG_CMD_RD_MATCH    8'he2
`define SDBG_CMD_WR_MATCH    8'hc2

// ----------------------------------------
// Timing, in debug-controller ticks; SDBG_ALT_DIV in system clock cycles per tick
// ----------------------------------------
`define SDBG_SYNC_DET_TICKS  8'd128
`define SDBG_SYNC_DLY_TICKS  8'd16
`define SDBG_SYNC_LOW_TICKS  8'd128
`define SDBG_BIT_SAMPLE_TICK 8'd10
`define SDBG_TX_LOW_TICKS    8'd13
`define SDBG_ALT_DIV         4

`endif

// file: design/sdbg_tick_div.v
`timescale 1ns/100ps
`default_nettype none

module sdbg_tick_div #(
    parameter integer DIV = 4
) (
    // Clock and reset
    input  wire       i_clk_sys,
    input  wire       i_resetn,
    // Enable pulse out
    output reg        o_tick
);

    reg [7:0] cnt_q;

    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_q  <= 8'h00;
            o_tick <= 1'b0;
        end else if (cnt_q == DIV[7:0] - 8'h01) begin
            cnt_q  <= 8'h00;
            o_tick <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 8'h01;
            o_tick <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// file: design/sdbg_match.v
`timescale 1ns/100ps
`default_nettype none

module sdbg_match (
    // Clock and reset
    input  wire        i_clk_sys,
    input  wire        i_resetn,
    // Configuration
    input  wire        i_match_enable,
    input  wire        i_force_or_tag_select,
    input  wire        i_debug_mode_permit,
    input  wire [15:0] i_match_addr,
    // Processor side
    input  wire [15:0] i_cpu_addr,
    input  wire        i_cpu_access,
    input  wire        i_cpu_opcode_fetch,
    input  wire        i_cpu_instr_boundary,
    input  wire        i_cpu_tag_at_end,
    // Requests
    output reg         o_tag_mark,
    output reg         o_enter_debug
);

    reg  force_pend_q;
    wire hit = i_match_enable && i_cpu_access && (i_cpu_addr == i_match_addr); // R9 R12

    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            force_pend_q  <= 1'b0;
            o_tag_mark    <= 1'b0;
            o_enter_debug <= 1'b0;
        end else begin
            // Tag travels with the opcode through the queue
            o_tag_mark <= hit && !i_force_or_tag_select && i_cpu_opcode_fetch; // R11 R13
            o_enter_debug <= 1'b0;
            if (!i_match_enable || !i_debug_mode_permit) begin
                force_pend_q <= 1'b0; // R12 R18
            end else if (force_pend_q && i_cpu_instr_boundary) begin
                force_pend_q  <= 1'b0;
                o_enter_debug <= 1'b1; // R10
            end else if (hit && i_force_or_tag_select) begin
                force_pend_q <= 1'b1; // R10 R13
            end
            if (i_cpu_tag_at_end && i_debug_mode_permit && i_match_enable) begin
                o_enter_debug <= 1'b1; // R11 R12
            end
        end
    end

endmodule
`default_nettype wire

// file: design/sdbg_top.v
`timescale 1ns/100ps
`default_nettype none
`include "sdbg_defs.vh"

module sdbg_top #(
    parameter integer ALT_DIV = `SDBG_ALT_DIV
) (
    // Clock and reset
    input  wire        i_clk_sys,
    input  wire        i_resetn,
    // Debug pin
    input  wire        i_debug_pin,
    output reg         o_debug_pin_out,
    output reg         o_debug_pin_oe,
    // Processor address and queue
    input  wire [15:0] i_cpu_addr,
    input  wire        i_cpu_access,
    input  wire        i_cpu_opcode_fetch,
    input  wire        i_cpu_instr_boundary,
    input  wire        i_cpu_tag_at_end,
    // Processor status
    input  wire        i_debug_mode_active,
    input  wire        i_wait_stop_status,
    input  wire        i_wait_stop_fail,
    input  wire        i_slow_access_fail,
    // Control to processor
    output reg         o_debug_mode_permit,
    output reg         o_comm_clock_select,
    output wire        o_tag_mark,
    output wire        o_enter_debug
);

    // ----------------------------------------
    // Line engine states
    // ----------------------------------------
    localparam [5:0] ST_IDLE    = 6'h01;
    localparam [5:0] ST_BIT     = 6'h02;
    localparam [5:0] ST_WAIT_HI = 6'h04;
    localparam [5:0] ST_DLY     = 6'h08;
    localparam [5:0] ST_ANS_LO  = 6'h10;
    localparam [5:0] ST_ANS_HI  = 6'h20;

    // Command layer phases
    localparam [2:0] PH_CMD = 3'h1;
    localparam [2:0] PH_RX  = 3'h2;
    localparam [2:0] PH_TX  = 3'h4;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg        pin_m_q;
    reg        pin_s_q;
    reg        pin_p_q;
    reg [5:0]  st_q;
    reg [7:0]  cnt_q;
    reg        sampled_q;
    reg        drive_bit_q;
    reg        rx_stb_q;
    reg        rx_bit_q;
    reg        sync_stb_q;

    reg [2:0]  ph_q;
    reg [4:0]  bitn_q;
    reg [4:0]  len_q;
    reg [7:0]  cmd_q;
    reg [15:0] sh_q;
    reg [15:0] txsh_q;

    reg        match_en_q;
    reg        fts_q;
    reg [15:0] match_addr_q;

    wire       alt_tick;
    wire       tick;
    wire       fall;
    wire [7:0] status_byte;
    wire [7:0] cmd_byte;
    wire [15:0] rx_word;

    // ----------------------------------------
    // Clock source and tick
    // ----------------------------------------
    sdbg_tick_div #(
        .DIV (ALT_DIV)
    ) u_div (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .o_tick    (alt_tick)
    );

    // Bus clock runs every cycle; alternate source is the divided enable
    assign tick = o_comm_clock_select ? 1'b1 : alt_tick; // R24 R22

    assign fall = pin_p_q && !pin_s_q;

    assign status_byte = {o_debug_mode_permit, i_debug_mode_active, match_en_q, fts_q,
                          o_comm_clock_select, i_wait_stop_status, i_wait_stop_fail,
                          i_slow_access_fail}; // R19 R16

    assign cmd_byte = {sh_q[6:0], rx_bit_q};
    assign rx_word  = {sh_q[14:0], rx_bit_q};

    // ----------------------------------------
    // Line engine: bits and speed probe
    // ----------------------------------------
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_m_q         <= 1'b1;
            pin_s_q         <= 1'b1;
            pin_p_q         <= 1'b1;
            st_q            <= ST_IDLE;
            cnt_q           <= 8'h00;
            sampled_q       <= 1'b0;
            drive_bit_q     <= 1'b0;
            rx_stb_q        <= 1'b0;
            rx_bit_q        <= 1'b0;
            sync_stb_q      <= 1'b0;
            o_debug_pin_out <= 1'b1;
            o_debug_pin_oe  <= 1'b0;
        end else begin
            pin_m_q    <= i_debug_pin;
            pin_s_q    <= pin_m_q;
            pin_p_q    <= pin_s_q;
            rx_stb_q   <= 1'b0;
            sync_stb_q <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    cnt_q          <= 8'h00;
                    sampled_q      <= 1'b0;
                    o_debug_pin_oe <= 1'b0;
                    if (fall) begin
                        st_q <= ST_BIT;
                        // A zero going out is held low past the host's own drive
                        drive_bit_q <= (ph_q == PH_TX) && !txsh_q[15];
                        if ((ph_q == PH_TX) && !txsh_q[15]) begin
                            o_debug_pin_oe  <= 1'b1;
                            o_debug_pin_out <= 1'b0;
                        end
                    end
                end
                ST_BIT: begin
                    if (tick) begin
                        if (cnt_q != 8'hff) begin
                            cnt_q <= cnt_q + 8'h01;
                        end
                        if ((cnt_q == `SDBG_BIT_SAMPLE_TICK - 8'h01) && !sampled_q) begin
                            sampled_q <= 1'b1;
                            rx_bit_q  <= pin_s_q;
                            rx_stb_q  <= 1'b1;
                        end
                        if (drive_bit_q && (cnt_q == `SDBG_TX_LOW_TICKS - 8'h01)) begin
                            o_debug_pin_out <= 1'b1;
                        end
                        if (drive_bit_q && (cnt_q == `SDBG_TX_LOW_TICKS)) begin
                            o_debug_pin_oe <= 1'b0;
                            drive_bit_q    <= 1'b0;
                        end
                        // Ordinary bits never stay low this long
                        if (!drive_bit_q && !pin_s_q
                            && (cnt_q == `SDBG_SYNC_DET_TICKS - 8'h01)) begin
                            st_q <= ST_WAIT_HI; // R1 R4 R2
                        end
                    end
                    if (sampled_q && !drive_bit_q && pin_s_q) begin
                        st_q <= ST_IDLE;
                    end
                end
                ST_WAIT_HI: begin
                    cnt_q <= 8'h00;
                    if (pin_s_q) begin
                        st_q       <= ST_DLY; // R5 R3
                        sync_stb_q <= 1'b1;
                    end
                end
                ST_DLY: begin
                    if (tick) begin
                        if (cnt_q == `SDBG_SYNC_DLY_TICKS - 8'h01) begin
                            cnt_q           <= 8'h00;
                            st_q            <= ST_ANS_LO;
                            o_debug_pin_oe  <= 1'b1; // R6
                            o_debug_pin_out <= 1'b0;
                        end else begin
                            cnt_q <= cnt_q + 8'h01; // R5
                        end
                    end
                end
                ST_ANS_LO: begin
                    if (tick) begin
                        if (cnt_q == `SDBG_SYNC_LOW_TICKS - 8'h01) begin
                            cnt_q           <= 8'h00;
                            st_q            <= ST_ANS_HI;
                            o_debug_pin_out <= 1'b1; // R7
                        end else begin
                            cnt_q <= cnt_q + 8'h01; // R6 R8
                        end
                    end
                end
                ST_ANS_HI: begin
                    if (tick) begin
                        o_debug_pin_oe <= 1'b0; // R7
                        st_q           <= ST_IDLE;
                    end
                end
                default: begin
                    st_q           <= ST_IDLE;
                    o_debug_pin_oe <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Command layer and debug registers
    // ----------------------------------------
    // Unknown codes are dropped; their framing is handled elsewhere
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            ph_q                <= PH_CMD;
            bitn_q              <= 5'h00;
            len_q               <= 5'h08;
            cmd_q               <= 8'h00;
            sh_q                <= 16'h0000;
            txsh_q              <= 16'hffff;
            o_debug_mode_permit <= `SDBG_RST_CTRL;
            match_en_q          <= `SDBG_RST_CTRL;
            fts_q               <= `SDBG_RST_CTRL;
            o_comm_clock_select <= `SDBG_RST_CTRL;
            match_addr_q        <= `SDBG_RST_MATCH;
        end else if (sync_stb_q) begin
            ph_q   <= PH_CMD; // R1
            bitn_q <= 5'h00;
            txsh_q <= 16'hffff;
        end else if (rx_stb_q) begin
            sh_q <= rx_word; // R23
            case (ph_q)
                PH_CMD: begin
                    if (bitn_q == 5'd7) begin
                        bitn_q <= 5'h00;
                        cmd_q  <= cmd_byte;
                        case (cmd_byte)
                            `SDBG_CMD_RD_STATUS: begin
                                ph_q   <= PH_TX; // R20
                                len_q  <= 5'd8;
                                txsh_q <= {status_byte, 8'hff};
                            end
                            `SDBG_CMD_RD_MATCH: begin
                                ph_q   <= PH_TX; // R21 R14
                                len_q  <= 5'd16;
                                txsh_q <= match_addr_q;
                            end
                            `SDBG_CMD_WR_CONTROL: begin
                                ph_q  <= PH_RX; // R20
                                len_q <= 5'd8;
                            end
                            `SDBG_CMD_WR_MATCH: begin
                                ph_q  <= PH_RX; // R21
                                len_q <= 5'd16;
                            end
                            default: begin
                                ph_q <= PH_CMD;
                            end
                        endcase
                    end else begin
                        bitn_q <= bitn_q + 5'h01;
                    end
                end
                PH_TX: begin
                    txsh_q <= {txsh_q[14:0], 1'b1}; // R23
                    if (bitn_q == len_q - 5'h01) begin
                        bitn_q <= 5'h00;
                        ph_q   <= PH_CMD;
                        txsh_q <= 16'hffff;
                    end else begin
                        bitn_q <= bitn_q + 5'h01;
                    end
                end
                PH_RX: begin
                    if (bitn_q == len_q - 5'h01) begin
                        bitn_q <= 5'h00;
                        ph_q   <= PH_CMD;
                        if (cmd_q == `SDBG_CMD_WR_MATCH) begin
                            match_addr_q <= rx_word; // R21 R9
                        end else begin
                            // Status flags have no storage here, so writes miss them
                            match_en_q          <= cmd_byte[`SDBG_BIT_MATCH_EN]; // R12 R16
                            fts_q               <= cmd_byte[`SDBG_BIT_FTS]; // R13
                            o_comm_clock_select <= cmd_byte[`SDBG_BIT_CLKSEL]; // R17 R22
                            if (!i_debug_mode_active && cmd_byte[`SDBG_BIT_PERMIT]) begin
                                o_debug_mode_permit <= 1'b1; // R15 R18
                            end
                        end
                    end else begin
                        bitn_q <= bitn_q + 5'h01;
                    end
                end
                default: begin
                    ph_q   <= PH_CMD;
                    bitn_q <= 5'h00;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Hardware breakpoint
    // ----------------------------------------
    sdbg_match u_match (
        .i_clk_sys             (i_clk_sys),
        .i_resetn              (i_resetn),
        .i_match_enable        (match_en_q),
        .i_force_or_tag_select (fts_q),
        .i_debug_mode_permit   (o_debug_mode_permit),
        .i_match_addr          (match_addr_q),
        .i_cpu_addr            (i_cpu_addr),
        .i_cpu_access          (i_cpu_access),
        .i_cpu_opcode_fetch    (i_cpu_opcode_fetch),
        .i_cpu_instr_boundary  (i_cpu_instr_boundary),
        .i_cpu_tag_at_end      (i_cpu_tag_at_end),
        .o_tag_mark            (o_tag_mark),
        .o_enter_debug         (o_enter_debug)
    );

endmodule
`default_nettype wire

// file: verif/sdbg_top_properties.sv
`timescale 1ns/100ps
`default_nettype none

module sdbg_checker #(
    parameter integer ALT_DIV = 4
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Debug pin
    input wire logic o_debug_pin_out,
    input wire logic o_debug_pin_oe,
    // Processor side
    input wire logic i_cpu_access,
    input wire logic i_cpu_opcode_fetch,
    input wire logic i_cpu_instr_boundary,
    input wire logic i_cpu_tag_at_end,
    input wire logic i_debug_mode_active,
    // Control and requests
    input wire logic o_debug_mode_permit,
    input wire logic o_comm_clock_select,
    input wire logic o_tag_mark,
    input wire logic o_enter_debug
);
    // ----------------------------------------
    // Pulse length counters
    // ----------------------------------------
    logic [11:0] low_cnt_q;
    logic [7:0]  hi_cnt_q;
    wire  [7:0]  tick_len = o_comm_clock_select ? 8'h01 : 8'(ALT_DIV);

    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            low_cnt_q <= 12'h000;
            hi_cnt_q  <= 8'h00;
        end else begin
            low_cnt_q <= (o_debug_pin_oe && !o_debug_pin_out) ? low_cnt_q + 12'h001 : 12'h000;
            hi_cnt_q  <= (o_debug_pin_oe && o_debug_pin_out) ? hi_cnt_q + 8'h01 : 8'h00;
        end
    end

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_enter_one_cycle: assert property (o_enter_debug |=> !o_enter_debug)
        else $error("enter request longer than one cycle");
    a_tag_one_cycle: assert property (o_tag_mark |=> !o_tag_mark)
        else $error("tag mark longer than one cycle");
    a_tag_from_fetch: assert property (o_tag_mark |-> $past(i_cpu_access && i_cpu_opcode_fetch))
        else $error("tag mark without opcode fetch");
    a_enter_has_cause: assert property
        (o_enter_debug |-> $past(i_cpu_instr_boundary || i_cpu_tag_at_end))
        else $error("enter request without boundary or queue end");
    a_enter_needs_permit: assert property (o_enter_debug |-> $past(o_debug_mode_permit))
        else $error("enter request while permit clear");
    a_permit_sticky: assert property (!$fell(o_debug_mode_permit))
        else $error("permit cleared without reset");
    a_permit_not_active: assert property
        ($rose(o_debug_mode_permit) |-> !$past(i_debug_mode_active))
        else $error("permit set while in debug mode");
    a_answer_low_len: assert property
        ($fell(o_debug_pin_oe && !o_debug_pin_out) && o_debug_pin_oe |->
         low_cnt_q < 16 * ALT_DIV || low_cnt_q == 128 * tick_len)
        else $error("answer low length wrong");
    a_speedup_one_tick: assert property
        ($fell(o_debug_pin_oe) |-> $past(o_debug_pin_out) && hi_cnt_q == tick_len)
        else $error("speedup pulse length wrong");

    c_sync_answer: cover property ($fell(o_debug_pin_oe) && low_cnt_q == 12'h000 && hi_cnt_q != 8'h00);
    c_enter: cover property (o_enter_debug);
    c_tag: cover property (o_tag_mark);
endmodule

bind sdbg_top sdbg_checker #(.ALT_DIV(ALT_DIV)) i_sdbg_checker (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .o_debug_pin_out(o_debug_pin_out),
    .o_debug_pin_oe(o_debug_pin_oe), .i_cpu_access(i_cpu_access),
    .i_cpu_opcode_fetch(i_cpu_opcode_fetch), .i_cpu_instr_boundary(i_cpu_instr_boundary),
    .i_cpu_tag_at_end(i_cpu_tag_at_end), .i_debug_mode_active(i_debug_mode_active),
    .o_debug_mode_permit(o_debug_mode_permit), .o_comm_clock_select(o_comm_clock_select),
    .o_tag_mark(o_tag_mark), .o_enter_debug(o_enter_debug));

`default_nettype wire

// file: verif/sdbg_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module sdbg_host_model #(
    parameter int SLOW = 4
) (
    // Clock and pin
    input  wire logic i_clk_sys,
    input  wire logic i_pin,
    // Open-drain style drive
    output var logic  o_drv_oe,
    output var logic  o_drv_out
);
    // Device ticks per clock cycle reciprocal, set by the bench
    int tk = 4;

    initial begin
        o_drv_oe = 1'h0;
        o_drv_out = 1'h1;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask

    task automatic pull_low(input int n);
        o_drv_out = 1'h0;
        o_drv_oe = 1'h1;
        wait_cyc(n);
        o_drv_oe = 1'h0;
    endtask

    // ----------------------------------------
    // Bit level
    // ----------------------------------------
    task automatic send_bits(input int n, input logic [23:0] v);
        for (int i = n - 1; i >= 0; i--) begin
            pull_low(v[i] ? 4 * tk : 20 * tk);
            wait_cyc(20 * tk);
        end
    endtask

    task automatic get_bits(input int n, output logic [15:0] v);
        v = 16'h0000;
        for (int i = n - 1; i >= 0; i--) begin
            pull_low(2 * tk);
            wait_cyc(6 * tk);
            v[i] = i_pin;
            wait_cyc(20 * tk);
        end
    endtask

    // ----------------------------------------
    // Speed probe
    // ----------------------------------------
    task automatic sync(output int dly, output int lo);
        dly = 0;
        lo = 0;
        o_drv_out = 1'h0;
        o_drv_oe = 1'h1;
        wait_cyc(130 * SLOW);
        o_drv_out = 1'h1;
        wait_cyc(1);
        o_drv_oe = 1'h0;
        while (i_pin === 1'h1 && dly < 2000) begin
            wait_cyc(1);
            dly++;
        end
        while (i_pin === 1'h0 && lo < 4000) begin
            wait_cyc(1);
            lo++;
        end
        wait_cyc(8);
    endtask
endmodule

`default_nettype wire

// file: verif/test_single_pin_debug_sync_breakpoint.sv
`timescale 1ns/100ps
`default_nettype none

module test_single_pin_debug_sync_breakpoint;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic [15:0] cpu_addr = 16'h0000;
    logic        acc = 1'h0, fetch = 1'h0, bnd = 1'h0, tend = 1'h0, act = 1'h0;
    logic [2:0]  st = 3'h0;
    wire         pin_out, pin_oe, h_oe, h_out, perm, clks, tag, ent;
    wire         pin = pin_oe ? pin_out : (h_oe ? h_out : 1'h1);
    logic [31:0] rnd = 32'h8734;
    logic [15:0] m = 16'h0000, got;
    logic        e_perm = 1'h0, e_men = 1'h0, e_fts = 1'h0, e_clk = 1'h0;
    logic        tag_seen = 1'h0, ent_seen = 1'h0;
    logic [7:0]  ctab [3] = '{8'hb8, 8'ha8, 8'h88};
    int          err_total = 0, tests_run = 0, dly, lo;

    always #5 clk = ~clk;

    sdbg_top i_sdbg_top (
        .i_clk_sys(clk), .i_resetn(rst_n), .i_debug_pin(pin), .o_debug_pin_out(pin_out),
        .o_debug_pin_oe(pin_oe), .i_cpu_addr(cpu_addr), .i_cpu_access(acc),
        .i_cpu_opcode_fetch(fetch), .i_cpu_instr_boundary(bnd), .i_cpu_tag_at_end(tend),
        .i_debug_mode_active(act), .i_wait_stop_status(st[2]), .i_wait_stop_fail(st[1]),
        .i_slow_access_fail(st[0]), .o_debug_mode_permit(perm), .o_comm_clock_select(clks),
        .o_tag_mark(tag), .o_enter_debug(ent));
    sdbg_host_model i_host (.i_clk_sys(clk), .i_pin(pin), .o_drv_oe(h_oe), .o_drv_out(h_out));

    always @(posedge clk) begin
        if (tag === 1'h1) tag_seen <= 1'h1;
        if (ent === 1'h1) ent_seen <= 1'h1;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic [15:0] stat_exp();
        return {8'h00, e_perm, act, e_men, e_fts, e_clk, st};
    endfunction

    task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_rng(input int g, input int lo_b, input int hi_b);
        tests_run++;
        if (g < lo_b || g > hi_b) begin
            err_total++;
            $display("ERROR %0t: count %0d outside %0d..%0d", $time, g, lo_b, hi_b);
        end
    endtask

    task automatic wr_ctrl(input logic [7:0] v);
        i_host.send_bits(16, {8'h00, 8'hc4, v});
        e_men = v[5];
        e_fts = v[4];
        e_clk = v[3];
        if (v[7] && !act) e_perm = 1'h1;
        i_host.tk = v[3] ? 1 : 4;
    endtask

    task automatic rd_stat();
        i_host.send_bits(8, 24'h0000e4);
        i_host.get_bits(8, got);
        chk_val(got, stat_exp());
    endtask

    task automatic do_sync();
        i_host.sync(dly, lo);
        chk_rng(lo, 128 * i_host.tk, 128 * i_host.tk);
        chk_rng(dly, 16 * i_host.tk - 1, 17 * i_host.tk + 4);
    endtask

    // Boundary held in the hit cycle: a forced break must wait for a later one
    task automatic bp(input logic [15:0] a, input logic f);
        logic hit;
        hit = e_men && a == m;
        cpu_addr = a;
        acc = 1'h1;
        fetch = f;
        bnd = 1'h1;
        tag_seen = 1'h0;
        ent_seen = 1'h0;
        @(posedge clk);
        #1;
        acc = 1'h0;
        fetch = 1'h0;
        bnd = 1'h0;
        cpu_addr = rnd[15:0];
        repeat (3) @(posedge clk);
        #1;
        chk_val(ent_seen, 16'h0000);
        chk_val(tag_seen, hit && !e_fts && f);
        if (e_fts) bnd = 1'h1;
        else tend = tag_seen;
        @(posedge clk);
        #1;
        bnd = 1'h0;
        tend = 1'h0;
        repeat (3) @(posedge clk);
        #1;
        chk_val(ent_seen, hit && e_perm && (e_fts || f));
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        #1;
        rst_n = 1'h1;
        chk_val({perm, clks, pin_oe, tag, ent}, 16'h0000);
        repeat (2) @(posedge clk);
        #1;
        rnd = lfsr(rnd);
        st = rnd[2:0];
        act = rnd[3];
        rd_stat();
        do_sync();
        act = 1'h1;
        rnd = lfsr(rnd);
        wr_ctrl(rnd[7:0] | 8'hb8);
        rd_stat();
        rnd = lfsr(rnd);
        m = rnd[15:0];
        i_host.send_bits(24, {8'hc2, m});
        i_host.send_bits(8, 24'h0000e2);
        i_host.get_bits(16, got);
        chk_val(got, m);
        act = 1'h0;
        bp(m, 1'h0);
        do_sync();
        for (int i = 0; i < 3; i++) begin
            wr_ctrl(ctab[i]);
            rd_stat();
            bp(m, 1'h0);
            bp(m, 1'h1);
            bp(m ^ 16'h0001, 1'h1);
        end
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            wr_ctrl({3'h1, rnd[0], 4'h8});
            bp(rnd[1] ? m : rnd[31:16], rnd[2]);
        end
        act = 1'h1;
        wr_ctrl(8'h30);
        rd_stat();
        tally_and_finish();
    end

    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        $display("ERROR %0t: timeout", $time);
        tally_and_finish();
    end
endmodule

`default_nettype wire
